// >>> common/cpu_pkg.sv
// Shared opcodes, flag layout, types and helpers for the decoder
package cpu_pkg;
  // Opcode bytes (second byte where a stack pre-byte leads)
  localparam logic [7:0] opc_test_page = 8'h3d;
  localparam logic [7:0] opc_test_acc = 8'h4d;
  localparam logic [7:0] opc_test_xlo = 8'h5d;
  localparam logic [7:0] opc_test_byte = 8'h6d;
  localparam logic [7:0] opc_test_noff = 8'h7d;
  localparam logic [7:0] opc_prefix = 8'h9e;
  localparam logic [7:0] opc_stack_to_index = 8'h95;
  localparam logic [7:0] opc_xlo_to_acc = 8'h9f;
  localparam logic [7:0] opc_index_to_stack = 8'h94;
  localparam logic [7:0] opc_load_full = 8'hc6;
  localparam logic [7:0] opc_load_word = 8'hd6;
  localparam logic [7:0] opc_load_byte = 8'he6;
  localparam logic [7:0] opc_mov_literal = 8'h6e;
  localparam logic [7:0] opc_mov_page_inc = 8'h5e;
  localparam logic [7:0] opc_mov_inc_page = 8'h7e;
  localparam logic [7:0] opc_cmp_br_page = 8'h31;
  localparam logic [7:0] opc_cmp_br_inc = 8'h71;
  localparam logic [7:0] opc_branch = 8'h20;

  // Flag register layout and reset values
  localparam int flag_v = 7;
  localparam int flag_n = 2;
  localparam int flag_z = 1;
  localparam logic [7:0] flag_reset = 8'h68;
  localparam logic [7:0] flag_keep_test = 8'h79;
  localparam logic [15:0] stack_reset = 16'h00ff;
  localparam logic [15:0] step = 16'h0001;
  localparam logic [7:0] page_high = 8'h00;
  localparam logic [7:0] zero_byte = 8'h00;

  typedef enum logic [3:0] {
    op_none, op_test_mem, op_test_acc, op_test_xlo, op_load,
    op_lit_move, op_page_inc_move, op_inc_page_move, op_cmp_branch,
    op_branch, op_stack_to_index, op_index_to_stack, op_xlo_to_acc
  } op_t;

  typedef enum logic [3:0] {
    implied_operand_mode, page_mode, full_address_mode,
    index_plain_mode, index_autoinc_mode, index_byte_offset_mode,
    index_word_offset_mode, stack_byte_offset_mode,
    stack_word_offset_mode, branch_offset_mode
  } amode_t;

  typedef struct packed {
    op_t op;
    amode_t mode;
  } decode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] index_pair;
    logic [15:0] stack_pointer;
    logic [15:0] pc;
    logic [7:0] flag_register;
  } arch_t;

  // Opcode to operation and operand form; pre marks a pre-byte seen
  function automatic decode_t decode(input logic [7:0] opc,
                                     input logic pre);
    decode_t d;
    d = '{op_none, implied_operand_mode};
    if (pre)
    begin
      case (opc)
        opc_test_byte: d = '{op_test_mem, stack_byte_offset_mode};
        opc_load_byte: d = '{op_load, stack_byte_offset_mode};
        opc_load_word: d = '{op_load, stack_word_offset_mode};
        default: d = '{op_none, implied_operand_mode};
      endcase
    end
    else
    begin
      case (opc)
        opc_test_page: d = '{op_test_mem, page_mode};
        opc_test_acc: d = '{op_test_acc, implied_operand_mode};
        opc_test_xlo: d = '{op_test_xlo, implied_operand_mode};
        opc_test_byte: d = '{op_test_mem, index_byte_offset_mode};
        opc_test_noff: d = '{op_test_mem, index_plain_mode};
        opc_stack_to_index: d = '{op_stack_to_index, implied_operand_mode};
        opc_xlo_to_acc: d = '{op_xlo_to_acc, implied_operand_mode};
        opc_index_to_stack: d = '{op_index_to_stack, implied_operand_mode};
        opc_load_full: d = '{op_load, full_address_mode};
        opc_load_word: d = '{op_load, index_word_offset_mode};
        opc_load_byte: d = '{op_load, index_byte_offset_mode};
        opc_mov_literal: d = '{op_lit_move, page_mode};
        opc_mov_page_inc: d = '{op_page_inc_move, page_mode};
        opc_mov_inc_page: d = '{op_inc_page_move, index_autoinc_mode};
        opc_cmp_br_page: d = '{op_cmp_branch, page_mode};
        opc_cmp_br_inc: d = '{op_cmp_branch, index_autoinc_mode};
        opc_branch: d = '{op_branch, branch_offset_mode};
        default: d = '{op_none, implied_operand_mode};
      endcase
    end
    return d;
  endfunction : decode

  // Flags after comparing a value with zero: V cleared, N and Z taken from the value
  function automatic logic [7:0] test_flags(input logic [7:0] f,
                                            input logic [7:0] v);
    logic [7:0] r;
    r = f;
    r[flag_v] = 1'b0;
    r[flag_n] = v[7];
    r[flag_z] = (v == zero_byte);
    return r;
  endfunction : test_flags

  // Two's-complement byte widened to an address offset
  function automatic logic [15:0] sext8(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction : sext8
endpackage : cpu_pkg

// >>> rtl/cpu_transfer_test_decode.sv
// Decode and execute for zero test, transfers and operand forms
module cpu_transfer_test_decode #(
  parameter logic [15:0] reset_pc = 16'h0000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] mem_rdata,
  output cpu_pkg::mem_req_t mem,
  output cpu_pkg::arch_t arch,
  output logic opcode_cycle,
  output logic illegal_opcode
);
  typedef enum logic [8:0] {
    st_decode = 9'h001,
    st_prefix = 9'h002,
    st_opnd_hi = 9'h004,
    st_opnd_lo = 9'h008,
    st_data_rd = 9'h010,
    st_data_wr = 9'h020,
    st_branch = 9'h040,
    st_literal = 9'h080,
    st_finish = 9'h100
  } state_t;

  state_t state;
  state_t next_state;
  cpu_pkg::decode_t dec;
  cpu_pkg::decode_t next_dec;
  cpu_pkg::decode_t fresh;
  logic [7:0] hi_byte;
  logic [7:0] next_hi;
  logic [7:0] tmp;
  logic [7:0] next_tmp;
  logic equal;
  logic next_equal;
  logic [7:0] next_acc;
  logic [15:0] next_hx;
  logic [15:0] next_stack;
  logic [15:0] next_pc;
  logic [7:0] next_flags;
  logic [15:0] next_addr;
  logic next_wr;
  logic [7:0] next_wdata;
  logic next_illegal;
  logic [15:0] ea;
  logic [15:0] pc_inc;
  logic [15:0] target;
  logic take;
  logic in_decode;

  // Operand bytes arrive in the same cycle that their address stands
  assign fresh = cpu_pkg::decode(mem_rdata, state == st_prefix);
  assign pc_inc = arch.pc + cpu_pkg::step;
  assign target = pc_inc + cpu_pkg::sext8(mem_rdata);
  assign take = (dec.op == cpu_pkg::op_branch) || equal;
  assign in_decode = (state == st_decode);

  ea_unit addr_calc (
    .mode(dec.mode),
    .index_pair(arch.index_pair),
    .stack_pointer(arch.stack_pointer),
    .hi(hi_byte),
    .lo(mem_rdata),
    .ea(ea)
  );

  // Sequencer: one memory access per cycle, opcode fetch overlapped
  always_comb
  begin
    next_state = state;
    next_dec = dec;
    next_hi = hi_byte;
    next_tmp = tmp;
    next_equal = equal;
    next_acc = arch.acc;
    next_hx = arch.index_pair;
    next_stack = arch.stack_pointer;
    next_pc = arch.pc;
    next_flags = arch.flag_register;
    next_addr = mem.addr;
    next_wr = 1'b0;
    next_wdata = mem.wdata;
    next_illegal = 1'b0;
    case (state)
      st_decode, st_prefix:
      begin
        next_dec = fresh;
        next_pc = pc_inc;
        next_addr = pc_inc;
        next_state = st_decode;
        if (in_decode && mem_rdata == cpu_pkg::opc_prefix)
        begin
          next_state = st_prefix;
        end
        else
        begin
          case (fresh.op)
            cpu_pkg::op_none: next_illegal = 1'b1;
            cpu_pkg::op_test_acc:
              next_flags = cpu_pkg::test_flags(arch.flag_register,
                                               arch.acc);
            cpu_pkg::op_test_xlo:
              next_flags = cpu_pkg::test_flags(arch.flag_register,
                                               arch.index_pair[7:0]);
            cpu_pkg::op_xlo_to_acc: next_acc = arch.index_pair[7:0];
            cpu_pkg::op_stack_to_index: next_state = st_finish;
            cpu_pkg::op_index_to_stack: next_state = st_finish;
            cpu_pkg::op_branch: next_state = st_branch;
            cpu_pkg::op_lit_move: next_state = st_literal;
            default:
            begin
              if (fresh.mode == cpu_pkg::index_plain_mode ||
                  fresh.mode == cpu_pkg::index_autoinc_mode)
              begin
                next_addr = arch.index_pair;
                next_state = st_data_rd;
              end
              else if (fresh.mode == cpu_pkg::full_address_mode ||
                       fresh.mode == cpu_pkg::index_word_offset_mode ||
                       fresh.mode == cpu_pkg::stack_word_offset_mode)
              begin
                next_state = st_opnd_hi;
              end
              else
              begin
                next_state = st_opnd_lo;
              end
            end
          endcase
        end
      end
      st_opnd_hi:
      begin
        next_hi = mem_rdata;
        next_pc = pc_inc;
        next_addr = pc_inc;
        next_state = st_opnd_lo;
      end
      st_opnd_lo:
      begin
        next_pc = pc_inc;
        next_addr = ea;
        if (dec.op == cpu_pkg::op_lit_move ||
            dec.op == cpu_pkg::op_inc_page_move)
        begin
          next_wr = 1'b1;
          next_wdata = tmp;
          next_state = st_data_wr;
        end
        else
        begin
          next_state = st_data_rd;
        end
      end
      st_data_rd:
      begin
        next_addr = arch.pc;
        next_state = st_decode;
        case (dec.op)
          cpu_pkg::op_test_mem:
            next_flags = cpu_pkg::test_flags(arch.flag_register,
                                             mem_rdata);
          cpu_pkg::op_load:
          begin
            next_acc = mem_rdata;
            next_flags = cpu_pkg::test_flags(arch.flag_register, mem_rdata);
          end
          cpu_pkg::op_page_inc_move:
          begin
            next_flags = cpu_pkg::test_flags(arch.flag_register, mem_rdata);
            next_addr = arch.index_pair;
            next_wr = 1'b1;
            next_wdata = mem_rdata;
            next_state = st_data_wr;
          end
          cpu_pkg::op_inc_page_move:
          begin
            next_flags = cpu_pkg::test_flags(arch.flag_register, mem_rdata);
            next_tmp = mem_rdata;
            next_hx = arch.index_pair + cpu_pkg::step;
            next_state = st_opnd_lo;
          end
          cpu_pkg::op_cmp_branch:
          begin
            next_equal = (arch.acc == mem_rdata);
            if (dec.mode == cpu_pkg::index_autoinc_mode)
            begin
              next_hx = arch.index_pair + cpu_pkg::step;
            end
            next_state = st_branch;
          end
          default: next_state = st_decode;
        endcase
      end
      st_data_wr:
      begin
        // Increment only once the write has left on the bus
        if (dec.op == cpu_pkg::op_page_inc_move)
        begin
          next_hx = arch.index_pair + cpu_pkg::step;
        end
        next_addr = arch.pc;
        next_state = st_decode;
      end
      st_literal:
      begin
        next_tmp = mem_rdata;
        // Moves flag the moved byte, like the other two move forms
        next_flags = cpu_pkg::test_flags(arch.flag_register, mem_rdata);
        next_pc = pc_inc;
        next_addr = pc_inc;
        next_state = st_opnd_lo;
      end
      st_branch:
      begin
        next_pc = take ? target : pc_inc;
        next_addr = next_pc;
        next_state = st_decode;
      end
      st_finish:
      begin
        // Second cycle of the pair transfers; flags stay untouched
        if (dec.op == cpu_pkg::op_stack_to_index)
        begin
          next_hx = arch.stack_pointer + cpu_pkg::step;
        end
        else
        begin
          next_stack = arch.index_pair - cpu_pkg::step;
        end
        next_state = st_decode;
      end
      default: next_state = st_decode;
    endcase
  end

  // Sequencer state and latched decode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= st_decode;
      dec <= '{cpu_pkg::op_none, cpu_pkg::implied_operand_mode};
      hi_byte <= cpu_pkg::zero_byte;
      tmp <= cpu_pkg::zero_byte;
      equal <= 1'b0;
      opcode_cycle <= 1'b1;
      illegal_opcode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      dec <= next_dec;
      hi_byte <= next_hi;
      tmp <= next_tmp;
      equal <= next_equal;
      opcode_cycle <= (next_state == st_decode);
      illegal_opcode <= next_illegal;
    end
  end

  // Programmer-visible registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arch.acc <= cpu_pkg::zero_byte;
      arch.index_pair <= {cpu_pkg::zero_byte, cpu_pkg::zero_byte};
      arch.stack_pointer <= cpu_pkg::stack_reset;
      arch.pc <= reset_pc;
      arch.flag_register <= cpu_pkg::flag_reset;
    end
    else
    begin
      arch.acc <= next_acc;
      arch.index_pair <= next_hx;
      arch.stack_pointer <= next_stack;
      arch.pc <= next_pc;
      arch.flag_register <= next_flags;
    end
  end

  // Memory request, registered so the pins never glitch
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem.addr <= reset_pc;
      mem.rd <= 1'b1;
      mem.wr <= 1'b0;
      mem.wdata <= cpu_pkg::zero_byte;
    end
    else
    begin
      mem.addr <= next_addr;
      mem.rd <= !next_wr;
      mem.wr <= next_wr;
      mem.wdata <= next_wdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence fetch_s(logic [7:0] opc);
    in_decode && mem_rdata == opc;
  endsequence

  sequence word_s(cpu_pkg::amode_t m);
    (state == st_opnd_hi && dec.mode == m) ##1 state == st_opnd_lo;
  endsequence

  test_flags_a: assert property (
    (state == st_data_rd && dec.op == cpu_pkg::op_test_mem) |=>
    (!arch.flag_register[cpu_pkg::flag_v] &&
     arch.flag_register[cpu_pkg::flag_n] == $past(mem_rdata[7]) &&
     arch.flag_register[cpu_pkg::flag_z] == ($past(mem_rdata) == 8'h00) &&
     (arch.flag_register & cpu_pkg::flag_keep_test) ==
     ($past(arch.flag_register) & cpu_pkg::flag_keep_test)))
    else $error("zero test flags wrong");

  test_page_cycles_a: assert property (
    fetch_s(cpu_pkg::opc_test_page) |->
    ##1 !in_decode ##1 !in_decode ##1 in_decode)
    else $error("page zero test not three cycles");

  test_stack_cycles_a: assert property (
    fetch_s(cpu_pkg::opc_prefix) ##1 mem_rdata == cpu_pkg::opc_test_byte
    |-> ##1 !in_decode [*2] ##1 in_decode)
    else $error("stack zero test not four cycles");

  stack_index_a: assert property (
    fetch_s(cpu_pkg::opc_stack_to_index) |-> ##1 !in_decode ##1
    (in_decode && arch.index_pair == $past(arch.stack_pointer, 2) + 16'h1
     && arch.flag_register == $past(arch.flag_register, 2)))
    else $error("stack to index pair wrong");

  xlo_acc_a: assert property (
    fetch_s(cpu_pkg::opc_xlo_to_acc) |=> in_decode &&
    arch.acc == $past(arch.index_pair[7:0]) && $stable(arch.flag_register))
    else $error("index low to accumulator wrong");

  index_stack_a: assert property (
    fetch_s(cpu_pkg::opc_index_to_stack) |-> ##1 !in_decode ##1
    (in_decode && arch.stack_pointer == $past(arch.index_pair, 2) - 16'h1
     && arch.flag_register == $past(arch.flag_register, 2)))
    else $error("index pair to stack wrong");

  full_addr_a: assert property (
    word_s(cpu_pkg::full_address_mode) |=>
    mem.addr == {$past(mem_rdata, 2), $past(mem_rdata)})
    else $error("full address byte order wrong");

  index_word_a: assert property (
    word_s(cpu_pkg::index_word_offset_mode) |=> mem.addr ==
    {$past(mem_rdata, 2), $past(mem_rdata)} + arch.index_pair)
    else $error("index word offset wrong");

  index_byte_a: assert property (
    (state == st_opnd_lo && dec.mode == cpu_pkg::index_byte_offset_mode)
    |=> mem.addr == $past(arch.index_pair) + {8'h00, $past(mem_rdata)})
    else $error("index byte offset wrong");

  autoinc_a: assert property (
    (state == st_data_rd && dec.mode == cpu_pkg::index_autoinc_mode) |->
    mem.addr == arch.index_pair ##1
    arch.index_pair == $past(arch.index_pair) + 16'h1)
    else $error("autoincrement wrong");

  inc_page_a: assert property (
    (state == st_data_rd && dec.op == cpu_pkg::op_inc_page_move) |=>
    state == st_opnd_lo ##1 (mem.wr && mem.wdata == $past(mem_rdata, 2)
    && mem.addr == {8'h00, $past(mem_rdata)}))
    else $error("index to page move wrong");

  page_inc_a: assert property (
    (state == st_data_rd && dec.op == cpu_pkg::op_page_inc_move) |=>
    (mem.wr && mem.addr == $past(arch.index_pair) &&
     mem.wdata == $past(mem_rdata)) ##1
    arch.index_pair == $past(arch.index_pair) + 16'h1)
    else $error("page to index move wrong");

  literal_a: assert property (
    state == st_literal |=> state == st_opnd_lo ##1
    (mem.wr && mem.wdata == $past(mem_rdata, 2) &&
     mem.addr == {8'h00, $past(mem_rdata)}))
    else $error("literal move wrong");

  stack_byte_a: assert property (
    (state == st_opnd_lo && dec.mode == cpu_pkg::stack_byte_offset_mode)
    |=> mem.addr == $past(arch.stack_pointer) + {8'h00, $past(mem_rdata)})
    else $error("stack byte offset wrong");

  stack_word_a: assert property (
    word_s(cpu_pkg::stack_word_offset_mode) |=> mem.addr ==
    {$past(mem_rdata, 2), $past(mem_rdata)} + arch.stack_pointer)
    else $error("stack word offset wrong");

  cmp_order_a: assert property (
    fetch_s(cpu_pkg::opc_cmp_br_page) |=> state == st_opnd_lo ##1
    state == st_data_rd ##1 state == st_branch ##1 in_decode)
    else $error("compare branch operand order wrong");

  branch_taken_a: assert property (
    (state == st_branch && take) |=> arch.pc ==
    $past(arch.pc) + 16'h1 + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)})
    else $error("branch target wrong");
endmodule : cpu_transfer_test_decode

// >>> rtl/ea_unit.sv
// Effective address forming for the memory operand forms
module ea_unit (
  input wire cpu_pkg::amode_t mode,
  input wire logic [15:0] index_pair,
  input wire logic [15:0] stack_pointer,
  input wire logic [7:0] hi,
  input wire logic [7:0] lo,
  output logic [15:0] ea
);
  logic [15:0] word;
  logic [15:0] byte_off;

  // Offsets are unsigned; carries ripple into the high address byte
  assign word = {hi, lo};
  assign byte_off = {cpu_pkg::page_high, lo};

  // Address per operand form
  always_comb
  begin
    case (mode)
      cpu_pkg::full_address_mode: ea = word;
      cpu_pkg::index_word_offset_mode: ea = index_pair + word;
      cpu_pkg::index_byte_offset_mode: ea = index_pair + byte_off;
      cpu_pkg::stack_byte_offset_mode: ea = stack_pointer + byte_off;
      cpu_pkg::stack_word_offset_mode: ea = stack_pointer + word;
      default: ea = byte_off;
    endcase
  end
endmodule : ea_unit

// >>> test/prog_mem.sv
// Combinational program and data memory that faces the decoder
module prog_mem (
  input wire logic clk,
  input wire cpu_pkg::mem_req_t req,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bytes [0:65535];
  logic tog = 1'b0;

  // Zero wait states; on write cycles the bus shows a toggling pattern
  assign rdata = req.rd ? bytes[req.addr] : {8{tog}};

  // Store on the edge that ends a write cycle
  always @(posedge clk)
  begin
    tog <= ~tog;
    if (req.wr)
      bytes[req.addr] <= req.wdata;
  end

  // Back-door load used before reset is released
  task load(input logic [15:0] a, input logic [7:0] d);
    bytes[a] = d;
  endtask : load

  initial
  begin
    foreach (bytes[i])
      bytes[i] = 8'h00;
  end
endmodule : prog_mem

// >>> test/tb_top.sv
// Program-driven bench for the decoder with a memory partner
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] rdata;
  cpu_pkg::mem_req_t req;
  cpu_pkg::arch_t arch;
  logic opc;
  logic ill;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] prog [] = '{8'h95, 8'h94, 8'h7e, 8'h40, 8'h9f, 8'h4d,
    8'h5d, 8'h3d, 8'h41, 8'h6d, 8'h10, 8'h7d, 8'h9e, 8'h6d, 8'h01,
    8'hc6, 8'h01, 8'h23, 8'hd6, 8'h00, 8'h20, 8'he6, 8'h05, 8'h9e,
    8'hd6, 8'h00, 8'h30, 8'h9e, 8'he6, 8'h02, 8'h6e, 8'h77, 8'h42,
    8'h5e, 8'h42, 8'h31, 8'h43, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h71, 8'h02, 8'h00, 8'h00, 8'h94, 8'h01, 8'h31, 8'h40, 8'h01,
    8'h20, 8'hfe};

  prog_mem prog_mem_inst (.clk(clk), .req(req), .rdata(rdata));

  cpu_transfer_test_decode cpu_transfer_test_decode_inst (
    .clk(clk), .resetn(resetn), .mem_rdata(rdata), .mem(req),
    .arch(arch), .opcode_cycle(opc), .illegal_opcode(ill));

  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Runs one instruction, counts its cycles, then checks the state
  task step(input int cyc, input logic [7:0] a, input logic [15:0] hx,
            input logic [7:0] f);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (opc !== 1'b1 && n < 20);
    check(16'(n), 16'(cyc));
    check({8'h00, arch.acc}, {8'h00, a});
    check(arch.index_pair, hx);
    check({8'h00, arch.flag_register}, {8'h00, f});
    check({15'h0000, ill}, 16'h0000);
  endtask : step

  // Transfers between stack, index pair and accumulator, with an autoincrement index to page move
  task transfers;
    step(2, 8'h00, 16'h0100, 8'h68);
    step(2, 8'h00, 16'h0100, 8'h68);
    check(arch.stack_pointer, 16'h00ff);
    step(4, 8'h00, 16'h0101, 8'h6c);
    check({8'h00, prog_mem_inst.bytes[16'h0040]}, 16'h0080);
    step(1, 8'h01, 16'h0101, 8'h6c);
  endtask : transfers

  // Every zero-test opcode with its cycle count and flags
  task zero_tests;
    step(1, 8'h01, 16'h0101, 8'h68);
    step(1, 8'h01, 16'h0101, 8'h68);
    step(3, 8'h01, 16'h0101, 8'h6a);
    step(3, 8'h01, 16'h0101, 8'h6c);
    step(2, 8'h01, 16'h0101, 8'h6a);
    step(4, 8'h01, 16'h0101, 8'h6c);
  endtask : zero_tests

  // Loads through the full, index and stack offset forms
  task operand_forms;
    step(4, 8'h5a, 16'h0101, 8'h68);
    step(4, 8'h11, 16'h0101, 8'h68);
    step(3, 8'h22, 16'h0101, 8'h68);
    step(5, 8'h33, 16'h0101, 8'h68);
    step(4, 8'h00, 16'h0101, 8'h6a);
  endtask : operand_forms

  // Literal and page moves, then a taken page compare and a taken autoincrement compare
  task moves_branches;
    step(4, 8'h00, 16'h0101, 8'h68);
    check({8'h00, prog_mem_inst.bytes[16'h0042]}, 16'h0077);
    step(4, 8'h00, 16'h0102, 8'h68);
    check({8'h00, prog_mem_inst.bytes[16'h0101]}, 16'h0077);
    step(4, 8'h00, 16'h0102, 8'h68);
    check(req.addr, 16'h002a);
    step(3, 8'h00, 16'h0103, 8'h68);
    check(req.addr, 16'h002e);
  endtask : moves_branches

  // Stack load from a moved index pair, unknown opcode, untaken compare
  task tail_forms;
    step(2, 8'h00, 16'h0103, 8'h68);
    check(arch.stack_pointer, 16'h0102);
    @(negedge clk);
    check({15'h0000, ill}, 16'h0001);
    check({15'h0000, opc}, 16'h0001);
    step(4, 8'h00, 16'h0103, 8'h68);
    check(req.addr, 16'h0033);
    step(2, 8'h00, 16'h0103, 8'h68);
    check(req.addr, 16'h0033);
    check(arch.pc, 16'h0033);
  endtask : tail_forms

  task wrap_up;
    $display("Errors: %0d, comparisons: %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Data bytes, reset, then the scenarios in program order
  initial
  begin
    // Let the memory clear itself before the program goes in
    #1;
    foreach (prog[i])
      prog_mem_inst.load(16'(i), prog[i]);
    prog_mem_inst.load(16'h0100, 8'h80);
    prog_mem_inst.load(16'h0111, 8'hff);
    prog_mem_inst.load(16'h0123, 8'h5a);
    prog_mem_inst.load(16'h0121, 8'h11);
    prog_mem_inst.load(16'h0106, 8'h22);
    prog_mem_inst.load(16'h012f, 8'h33);
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    transfers();
    zero_tests();
    operand_forms();
    moves_branches();
    tail_forms();
    wrap_up();
  end

  // Backstop only: each step stops after 20 cycles, so a hung decoder still reaches the closing task
  initial
  begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule : tb_top
